//--- csp_defs.svh
// Constants of the CPU status and pointer register block.
// Assumes inclusion by bare name from the package and the modules.
// Overview of operation
// [RQ1] Reset input active high, synchronised internally
// [RQ2] Source holds reset at least 12 clocks
// [RQ3] Bank bits place registers at 00/08/10/18
// [RQ4] Parity flag shows odd count of accumulator ones
// [RQ5] Carry flag records carry or borrow out
// [RQ6] Half carry updated by decimal arithmetic
// [RQ7] Overflow flag flags signed result overflow
// [RQ8] User flags hold what software writes
// [RQ9] Eight separate 16-bit data pointers
// [RQ10] Only selected pointer visible, others kept
// [RQ11] Pointer select resets to zero
// [RQ12] Status word resets to 00
// [RQ13] Internal data memory 256 bytes, banks lowest
// [RQ14] Special register area separate 128 bytes
// [RQ15] Pointers reach 64 Kbyte external data
// [RQ16] Parity bit follows hardware, writes ignored
`ifndef CSP_DEFS_SVH
`define CSP_DEFS_SVH

// Byte addresses on the register bus
`define CSP_OFS_PTR_VAL  12'h084
`define CSP_OFS_PTR_SEL  12'h090
`define CSP_OFS_PSW      12'h0D0
`define CSP_OFS_ACC      12'h0E0
`define CSP_SFR_BASE     12'h080
`define CSP_SFR_SIZE     12'h080
`define CSP_RAM_BASE     12'h400
`define CSP_RAM_SIZE     12'h400

// Status word field positions
`define CSP_BIT_CARRY    7
`define CSP_BIT_HALF     6
`define CSP_BIT_USER0    5
`define CSP_BIT_BANK_HI  4
`define CSP_BIT_BANK_LO  3
`define CSP_BIT_OVF      2
`define CSP_BIT_USER1    1
`define CSP_BIT_PARITY   0

// Reset values
`define CSP_RST_PSW      8'h00
`define CSP_RST_PTR_SEL  3'h0
`define CSP_RST_ACC      8'h00
`define CSP_RST_PTR      16'h0000

// Reset synchroniser depth
`define CSP_SYNC_STAGES  2

`endif

//--- csp_flag_unit.sv
// Next status word from bus writes, result flags, accumulator.
// Assumes the caller registers the result.
`timescale 1ns/1ps
`include "csp_defs.svh"
module csp_flag_unit
  import csp_pkg::*;
(
  input  wire logic        [7:0] i_psw,
  input  wire logic              i_bus_we,
  input  wire logic        [7:0] i_bus_data,
  input  wire csp_alu_type       i_alu,
  input  wire logic        [7:0] i_next_acc,
  output logic             [7:0] o_next_psw
);
  logic [7:0] base;

  // Software sets flags, user bits and bank
  assign base = i_bus_we ? i_bus_data : i_psw; // RQ8

  // Hardware results win over a same-cycle software write
  always_comb begin
    o_next_psw = base;
    if (i_alu.carry_we) begin
      o_next_psw[`CSP_BIT_CARRY] = i_alu.carry; // RQ5
    end
    if (i_alu.half_we) begin
      o_next_psw[`CSP_BIT_HALF] = i_alu.half; // RQ6
    end
    if (i_alu.ovf_we) begin
      o_next_psw[`CSP_BIT_OVF] = i_alu.ovf; // RQ7
    end
    // Parity is never taken from the write data
    o_next_psw[`CSP_BIT_PARITY] = ^i_next_acc; // RQ4 RQ16
  end
endmodule : csp_flag_unit

//--- csp_pkg.sv
// Types shared by the status and pointer register block.
// Assumes csp_defs.svh on the include path.
package csp_pkg;
  `include "csp_defs.svh"

  // Result flags from the execution unit
  typedef struct packed {
    logic       carry_we;
    logic       carry;
    logic       half_we;
    logic       half;
    logic       ovf_we;
    logic       ovf;
    logic       acc_we;
    logic [7:0] acc;
  } csp_alu_type;

  // Working register access by register number
  typedef struct packed {
    logic       we;
    logic [2:0] num;
    logic [7:0] wdata;
  } csp_reg_req_type;

  // Data pointer load from the execution unit
  typedef struct packed {
    logic        we;
    logic [15:0] value;
  } csp_ptr_req_type;

  // Bus answer sequencing
  typedef enum logic {
    CSP_BUS_IDLE,
    CSP_BUS_ANSWER
  } csp_bus_state_type;
endpackage : csp_pkg

//--- csp_reset_sync.sv
// Reset synchroniser: async assert, release on the clock.
// Assumes i_rst is an active-high pin level.
`timescale 1ns/1ps
`include "csp_defs.svh"
module csp_reset_sync
  import csp_pkg::*;
(
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  output logic      o_rst_sync
);
  logic [`CSP_SYNC_STAGES-1:0] stage;

  // Release passes two flops so no state sees a metastable edge
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      stage <= '1;
    end else begin
      stage <= {stage[`CSP_SYNC_STAGES-2:0], 1'b0}; // RQ1
    end
  end

  assign o_rst_sync = stage[`CSP_SYNC_STAGES-1];
endmodule : csp_reset_sync

//--- csp_top.sv
// Status word, register banks, data memory and data pointers.
// Assumes a classic Wishbone master and an execution unit
// that reports results as one-cycle strobes.
// Limitation: one request per ack, no pipelined bursts.
// Data memory is not cleared by reset.
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "csp_defs.svh"

module csp_top
  import csp_pkg::*;
(
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_wb_cyc,
  input  wire logic                 i_wb_stb,
  input  wire logic                 i_wb_we,
  input  wire logic          [11:0] i_wb_adr,
  input  wire logic          [3:0]  i_wb_sel,
  input  wire logic          [31:0] i_wb_dat,
  output logic               [31:0] o_wb_dat,
  output logic                      o_wb_ack,
  input  wire csp_alu_type          i_alu,
  input  wire csp_reg_req_type      i_reg_req,
  output logic               [7:0]  o_reg_rdata,
  input  wire csp_ptr_req_type      i_ptr_req,
  output logic               [15:0] o_ptr,
  output logic               [7:0]  o_psw,
  output logic               [7:0]  o_bank_base
);

  //////////////////////////////////////////////////////////////////
  // Helpers

  // Bank bits and register number to a data memory byte
  function automatic logic [7:0] bank_addr(
    input logic [1:0] bank,
    input logic [2:0] num
  );
    bank_addr = {3'h0, bank, num}; // RQ3
  endfunction : bank_addr

  // Word address match within the register space
  function automatic logic hit(
    input logic [11:0] adr,
    input logic [11:0] ofs
  );
    hit = (adr[11:2] == ofs[11:2]);
  endfunction : hit

  // Byte register zero-extended onto the 32-bit read bus
  function automatic logic [31:0] byte_word(
    input logic [7:0] b
  );
    byte_word = {24'h00_0000, b};
  endfunction : byte_word

  //////////////////////////////////////////////////////////////////
  // Reset

  logic rst_sync;

  // All state below sees only the synchronised reset
  csp_reset_sync u_reset_sync (
    .i_sys_clk  (i_sys_clk),
    .i_rst      (i_rst),
    .o_rst_sync (rst_sync)
  ); // RQ1

  //////////////////////////////////////////////////////////////////
  // Storage

  // Data memory alone has no reset; clearing it would cost a wide mux
  logic [7:0]  program_status_word;
  logic [7:0]  acc;
  logic [2:0]  ptr_sel;
  logic [15:0] ptr_bank [0:7];            // RQ9 RQ15
  logic [7:0]  data_mem [0:255];          // RQ13
  csp_bus_state_type bus_state;

  //////////////////////////////////////////////////////////////////
  // Bus decode

  // Decode reads the live address; the master holds it until ack
  logic        req;
  logic        take;
  logic        wr_now;
  logic        in_sfr;
  logic        in_ram;
  logic        sel_psw;
  logic        sel_acc;
  logic        sel_psel;
  logic        sel_pval;
  logic        mapped;
  logic [7:0]  ram_idx;
  logic [7:0]  wr_byte;
  logic        lane0;
  logic        lane1;

  // A request is live while cyc and stb are both high
  assign req     = i_wb_cyc & i_wb_stb;
  // Taken only while idle, so the ack cycle never restarts the answer
  assign take    = req & (bus_state == CSP_BUS_IDLE);
  // Writes land on the edge where the master sees ack
  assign wr_now  = req & i_wb_we & o_wb_ack;
  // Two separate windows, special area and data memory
  assign in_sfr  = (i_wb_adr >= `CSP_SFR_BASE) &&
                   (i_wb_adr < (`CSP_SFR_BASE + `CSP_SFR_SIZE)); // RQ14
  assign in_ram  = (i_wb_adr >= `CSP_RAM_BASE) &&
                   (i_wb_adr < (`CSP_RAM_BASE + `CSP_RAM_SIZE)); // RQ13
  assign sel_psw  = in_sfr & hit(i_wb_adr, `CSP_OFS_PSW);
  assign sel_acc  = in_sfr & hit(i_wb_adr, `CSP_OFS_ACC);
  assign sel_psel = in_sfr & hit(i_wb_adr, `CSP_OFS_PTR_SEL);
  assign sel_pval = in_sfr & hit(i_wb_adr, `CSP_OFS_PTR_VAL);
  assign mapped   = sel_psw | sel_acc | sel_psel | sel_pval | in_ram;
  // One byte per word in the memory window
  assign ram_idx  = i_wb_adr[9:2];
  assign wr_byte  = i_wb_dat[7:0];
  assign lane0    = i_wb_sel[0];
  assign lane1    = i_wb_sel[1];

  //////////////////////////////////////////////////////////////////
  // Write strobes per target

  logic wr_psw;
  logic wr_acc;
  logic wr_psel;
  logic wr_plo;
  logic wr_phi;
  logic wr_ram;

  // Byte lanes gate every write; lane 1 only for the pointer
  // Every strobe needs the ack cycle, so each write lands once
  assign wr_psw  = wr_now & sel_psw & lane0;
  assign wr_acc  = wr_now & sel_acc & lane0;
  assign wr_psel = wr_now & sel_psel & lane0;
  assign wr_plo  = wr_now & sel_pval & lane0;
  assign wr_phi  = wr_now & sel_pval & lane1;
  assign wr_ram  = wr_now & in_ram & lane0;

  //////////////////////////////////////////////////////////////////
  // Accumulator and status word

  logic [7:0] next_acc;
  logic [7:0] next_psw;

  // Execution result has priority over a software write
  assign next_acc = i_alu.acc_we ? i_alu.acc :
                    wr_acc       ? wr_byte   : acc;

  // Flag unit sees the post-edge accumulator, so parity never lags
  csp_flag_unit u_flag_unit (
    .i_psw      (program_status_word),
    .i_bus_we   (wr_psw),
    .i_bus_data (wr_byte),
    .i_alu      (i_alu),
    .i_next_acc (next_acc),
    .o_next_psw (next_psw)
  );

  // Parity rides along every accumulator change
  always_ff @(posedge i_sys_clk or posedge rst_sync) begin
    if (rst_sync) begin
      acc <= `CSP_RST_ACC;
      program_status_word <= `CSP_RST_PSW; // RQ12
    end else begin
      acc <= next_acc;
      program_status_word <= next_psw; // RQ4
    end
  end

  //////////////////////////////////////////////////////////////////
  // Working register banks

  logic [1:0] bank;
  logic [1:0] next_bank;
  logic [7:0] cpu_addr;

  // Bank field of the live status word
  assign bank      = {program_status_word[`CSP_BIT_BANK_HI], program_status_word[`CSP_BIT_BANK_LO]};
  assign next_bank = {next_psw[`CSP_BIT_BANK_HI],
                      next_psw[`CSP_BIT_BANK_LO]};
  assign cpu_addr  = bank_addr(bank, i_reg_req.num); // RQ3

  // Two write ports; the execution unit wins on a clash
  // Contents stay undefined until written
  always_ff @(posedge i_sys_clk) begin
    if (wr_ram) begin
      data_mem[ram_idx] <= wr_byte;
    end
    if (i_reg_req.we) begin
      data_mem[cpu_addr] <= i_reg_req.wdata; // RQ3
    end
  end

  // Registered read of the addressed working register
  // Base follows the bank that the next access will use
  always_ff @(posedge i_sys_clk or posedge rst_sync) begin
    if (rst_sync) begin
      o_reg_rdata <= 8'h00;
      o_bank_base <= 8'h00;
    end else begin
      o_reg_rdata <= data_mem[cpu_addr];
      o_bank_base <= bank_addr(next_bank, 3'h0); // RQ3
    end
  end

  //////////////////////////////////////////////////////////////////
  // Data pointers

  logic [15:0] cur_ptr;
  logic [15:0] next_ptr;

  // Only the selected pointer is loaded or read over the bus
  assign cur_ptr = ptr_bank[ptr_sel]; // RQ10

  // Execution load beats a same-cycle software write
  // Software may load the two bytes one lane at a time
  always_comb begin
    next_ptr = cur_ptr;
    if (wr_plo) begin
      next_ptr[7:0] = i_wb_dat[7:0];
    end
    if (wr_phi) begin
      next_ptr[15:8] = i_wb_dat[15:8];
    end
    if (i_ptr_req.we) begin
      next_ptr = i_ptr_req.value;
    end
  end

  // Unselected pointers keep their contents
  always_ff @(posedge i_sys_clk or posedge rst_sync) begin
    if (rst_sync) begin
      for (int i = 0; i < 8; i++) begin
        ptr_bank[i] <= `CSP_RST_PTR;
      end
    end else begin
      ptr_bank[ptr_sel] <= next_ptr; // RQ9 RQ10
    end
  end

  //////////////////////////////////////////////////////////////////
  // Pointer select

  logic [2:0] next_ptr_sel;

  // Upper five bits are not stored and read as zero
  assign next_ptr_sel = wr_psel ? wr_byte[2:0] : ptr_sel;

  always_ff @(posedge i_sys_clk or posedge rst_sync) begin
    if (rst_sync) begin
      ptr_sel <= `CSP_RST_PTR_SEL; // RQ11
    end else begin
      ptr_sel <= next_ptr_sel;
    end
  end

  // Pointer output follows the post-edge selection
  always_ff @(posedge i_sys_clk or posedge rst_sync) begin
    if (rst_sync) begin
      o_ptr <= `CSP_RST_PTR;
    end else if (next_ptr_sel == ptr_sel) begin
      o_ptr <= next_ptr; // RQ15
    end else begin
      o_ptr <= ptr_bank[next_ptr_sel]; // RQ10
    end
  end

  //////////////////////////////////////////////////////////////////
  // Read data selection

  logic [31:0] rd_word;

  // Unmapped words answer with zero
  // Captured when the request is taken, not at the ack edge
  always_comb begin
    rd_word = 32'h0000_0000;
    if (sel_psw) begin
      rd_word = byte_word(program_status_word);
    end else if (sel_acc) begin
      rd_word = byte_word(acc);
    end else if (sel_psel) begin
      rd_word = {29'h0000_0000, ptr_sel};
    end else if (sel_pval) begin
      rd_word = {16'h0000, cur_ptr};
    end else if (in_ram) begin
      rd_word = byte_word(data_mem[ram_idx]);
    end
  end

  //////////////////////////////////////////////////////////////////
  // Bus answer

  csp_bus_state_type next_bus_state;

  // One wait cycle, then ack for exactly one cycle
  // Trade-off: the wait cycle keeps decode off the ack path
  always_comb begin
    case (bus_state)
      CSP_BUS_IDLE: begin
        next_bus_state = req ? CSP_BUS_ANSWER : CSP_BUS_IDLE;
      end
      CSP_BUS_ANSWER: begin
        next_bus_state = CSP_BUS_IDLE;
      end
      default: begin
        next_bus_state = CSP_BUS_IDLE;
      end
    endcase
  end

  // Ack and data leave flops; every word acks, mapped or not
  always_ff @(posedge i_sys_clk or posedge rst_sync) begin
    if (rst_sync) begin
      bus_state <= CSP_BUS_IDLE;
      o_wb_ack  <= 1'b0;
      o_wb_dat  <= 32'h0000_0000;
    end else begin
      bus_state <= next_bus_state;
      o_wb_ack  <= take;
      if (take & ~i_wb_we & mapped) begin
        o_wb_dat <= rd_word;
      end else if (take) begin
        o_wb_dat <= 32'h0000_0000;
      end
    end
  end

  //////////////////////////////////////////////////////////////////
  // Status word out

  // Mirror of the status word for the rest of the core
  // Own flop so the output carries no decode behind it
  always_ff @(posedge i_sys_clk or posedge rst_sync) begin
    if (rst_sync) begin
      o_psw <= `CSP_RST_PSW; // RQ12
    end else begin
      o_psw <= next_psw;
    end
  end

endmodule : csp_top

//--- csp_top_sva.sv
// Port-level checker for the status and pointer register block.
// Assumes one clock domain and the bind below onto csp_top.
`timescale 1ns/1ps
module csp_top_sva
  import csp_pkg::*;
(
  input wire logic            i_sys_clk,
  input wire logic            i_rst,
  input wire logic            i_wb_cyc,
  input wire logic            i_wb_stb,
  input wire logic            i_wb_we,
  input wire logic     [11:0] i_wb_adr,
  input wire logic     [3:0]  i_wb_sel,
  input wire logic     [31:0] i_wb_dat,
  input wire logic     [31:0] o_wb_dat,
  input wire logic            o_wb_ack,
  input wire csp_alu_type     i_alu,
  input wire csp_reg_req_type i_reg_req,
  input wire logic     [7:0]  o_reg_rdata,
  input wire csp_ptr_req_type i_ptr_req,
  input wire logic     [15:0] o_ptr,
  input wire logic     [7:0]  o_psw,
  input wire logic     [7:0]  o_bank_base
);
  // All checks share the system clock and the pin reset
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer: exactly one cycle after the request is taken
  AST_ACK_ONE: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("ack missing one cycle after request");
  AST_ACK_PULSE: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property ($rose(o_wb_ack) |-> $past(i_wb_cyc && i_wb_stb))
    else $error("ack without request");

  ////////////////////////////////////////////////////////////////////////////
  // Flags follow the execution unit strobes; bank base, hold and reset checks
  AST_CARRY: assert property (i_alu.carry_we |=> o_psw[7] == $past(i_alu.carry))
    else $error("carry flag not loaded");
  AST_HALF: assert property (i_alu.half_we |=> o_psw[6] == $past(i_alu.half))
    else $error("half carry not loaded");
  AST_OVF: assert property (i_alu.ovf_we |=> o_psw[2] == $past(i_alu.ovf))
    else $error("overflow flag not loaded");
  AST_PARITY: assert property (i_alu.acc_we |=> o_psw[0] == ^$past(i_alu.acc))
    else $error("parity does not follow accumulator");
  AST_BANK: assert property (o_bank_base == {3'h0, o_psw[4:3], 3'h0})
    else $error("bank base differs from bank bits");
  AST_HOLD: assert property (!i_wb_cyc && !i_alu.carry_we && !i_alu.half_we &&
    !i_alu.ovf_we && !i_alu.acc_we |=> $stable(o_psw))
    else $error("status word changed without cause");
  AST_RST: assert property ($fell(i_rst) |-> o_psw == 8'h00 && o_ptr == 16'h0000)
    else $error("state not cleared by reset");
endmodule : csp_top_sva

bind csp_top csp_top_sva u_sva (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_alu(i_alu), .i_reg_req(i_reg_req),
  .o_reg_rdata(o_reg_rdata), .i_ptr_req(i_ptr_req), .o_ptr(o_ptr), .o_psw(o_psw),
  .o_bank_base(o_bank_base)
);

//--- test_cpu_status_and_pointer_regs.sv
// Self-checking bench for the status and pointer register block.
// Assumes csp_pkg compiled first and the checker bound to csp_top.
`timescale 1ns/1ps
module test_cpu_status_and_pointer_regs
  import csp_pkg::*;
;
  logic            clk  = 1'b0;
  logic            rst  = 1'b1;
  logic            cyc  = 1'b0;
  logic            stb  = 1'b0;
  logic            we   = 1'b0;
  logic     [11:0] adr  = 12'h000;
  logic     [3:0]  sel  = 4'h0;
  logic     [31:0] wdat = 32'h00000000;
  logic     [31:0] rd;
  logic     [31:0] lf   = 32'h0000BEB8;
  csp_alu_type     alu  = '0;
  csp_alu_type     a;
  csp_reg_req_type rq   = '0;
  csp_ptr_req_type pq   = '0;
  wire logic [31:0] wb_dat;
  wire logic        ack;
  wire logic [7:0]  reg_rd;
  wire logic [7:0]  program_status_word;
  wire logic [7:0]  bbase;
  wire logic [15:0] ptr;
  logic     [7:0]  mpsw;
  logic     [7:0]  macc;
  logic     [7:0]  v;
  logic     [15:0] mptr [8];
  int              err_count = 0;
  int              compares  = 0;

  // Free-running 50 MHz clock
  always #10 clk = ~clk;

  csp_top u_dut (
    .i_sys_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(wb_dat), .o_wb_ack(ack),
    .i_alu(alu), .i_reg_req(rq), .o_reg_rdata(reg_rd), .i_ptr_req(pq), .o_ptr(ptr),
    .o_psw(program_status_word), .o_bank_base(bbase)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Repeatable random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Expected bank base from a status word
  function automatic logic [7:0] bank_base(input logic [7:0] p);
    return {3'h0, p[4:3], 3'h0};
  endfunction : bank_base

  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // Classic single cycle; wait bounded so a dead slave cannot hang the run
  task automatic wb(input logic w, input logic [11:0] ad, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= d;
    sel <= s;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      err_count++;
      final_report();
    end
    rd = wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  // One-cycle execution strobe, then settle past the update edge
  task automatic exe(input csp_alu_type x);
    @(posedge clk);
    alu <= x;
    @(posedge clk);
    alu <= '0;
    #1;
  endtask : exe

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk(program_status_word, 8'h00);
    wb(1'b0, 12'h090, 32'h0, 4'hF);
    chk(rd, 32'h0);
    wb(1'b0, 12'h300, 32'h0, 4'hF);
    chk(rd, 32'h0);
    // Status word, parity, banks and bank-relative registers
    for (int i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      macc = lf[7:0];
      v = lf[15:8];
      v[4:3] = i[1:0];
      wb(1'b1, 12'h0E0, {24'h0, macc}, 4'h1);
      wb(1'b1, 12'h0D0, {24'h0, v}, 4'h1);
      wb(1'b1, 12'h0D0, {24'h0, ~v}, 4'h2);
      wb(1'b0, 12'h0D0, 32'h0, 4'hF);
      chk(rd, {24'h0, v[7:1], ^macc});
      chk(bbase, bank_base(v));
      @(posedge clk);
      rq <= {1'b1, lf[18:16], lf[31:24]};
      @(posedge clk);
      rq <= {1'b0, lf[18:16], 8'h00};
      @(posedge clk);
      #1;
      chk(reg_rd, lf[31:24]);
      wb(1'b0, {2'b01, 3'b000, v[4:3], lf[18:16], 2'b00}, 32'h0, 4'hF);
      chk(rd, {24'h0, lf[31:24]});
    end
    mpsw = {v[7:1], ^macc};
    // Random execution results
    for (int i = 0; i < 12; i++) begin
      lf = lfsr(lf);
      a = lf[14:0];
      exe(a);
      if (a.carry_we) mpsw[7] = a.carry;
      if (a.half_we) mpsw[6] = a.half;
      if (a.ovf_we) mpsw[2] = a.ovf;
      if (a.acc_we) macc = a.acc;
      mpsw[0] = ^macc;
      chk(program_status_word, mpsw);
    end
    wb(1'b0, 12'h0E0, 32'h0, 4'hF);
    chk(rd, {24'h0, macc});
    // Carry strobe in the very cycle a software write lands: hardware wins
    a = '0;
    a.carry_we = 1'b1;
    a.carry = ~mpsw[7];
    fork
      wb(1'b1, 12'h0D0, {24'h0, mpsw}, 4'h1);
      begin
        repeat (2) @(posedge clk);
        alu <= a;
        @(posedge clk);
        alu <= '0;
      end
    join
    mpsw[7] = a.carry;
    #1;
    chk(program_status_word, mpsw);
    // Eight pointers, each kept while others are loaded
    for (int k = 0; k < 8; k++) begin
      lf = lfsr(lf);
      mptr[k] = lf[15:0];
      wb(1'b1, 12'h090, k, 4'h1);
      wb(1'b1, 12'h084, {16'h0, mptr[k]}, 4'h3);
    end
    for (int k = 7; k >= 0; k--) begin
      wb(1'b1, 12'h090, {29'h0, k[2:0]}, 4'h1);
      wb(1'b0, 12'h084, 32'h0, 4'hF);
      chk(rd, {16'h0, mptr[k]});
      chk(ptr, mptr[k]);
    end
    wb(1'b1, 12'h090, 32'hFD, 4'h1);
    wb(1'b0, 12'h090, 32'h0, 4'hF);
    chk(rd, 32'h05);
    @(posedge clk);
    pq <= {1'b1, 16'hFFFF};
    @(posedge clk);
    pq <= '0;
    #1;
    chk(ptr, 16'hFFFF);
    wb(1'b1, 12'h090, 32'h0, 4'h1);
    wb(1'b0, 12'h084, 32'h0, 4'hF);
    chk(rd, {16'h0, mptr[0]});
    // Reset in mid-run with a non-zero bank and pointer selected
    wb(1'b1, 12'h0D0, 32'h18, 4'h1);
    wb(1'b1, 12'h090, 32'h3, 4'h1);
    @(posedge clk);
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk(program_status_word, 8'h00);
    chk(bbase, bank_base(8'h00));
    chk(ptr, 16'h0000);
    wb(1'b0, 12'h090, 32'h0, 4'hF);
    chk(rd, 32'h0);
    final_report();
  end
endmodule : test_cpu_status_and_pointer_regs
